// File: design/ctsc_top.sv
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - ten-bit reference capacitor code, low byte plus two high bits, resets zero
// - control 0 bit 6 routes pad one (0) or pad two (1) to counting
// - control 0 bit 5 doubles the key oscillator frequency when set
// - control 0 bit 3 selects software hop field (0) or hardware hopping (1)
// - three-bit hop field picks oscillator frequency, used only in software mode
// - control 1 bit 7 clocks slot counters from reference osc or sysclk/4
// - control 1 bits 5 and 4 enable reference and key oscillators
// - control 1 bits 1 and 0 make pad two and pad one touch inputs
// - start low clears sense, function and unit counters, not the slot counter
// - start rising switches all counters on with oscillators synchronised
// - slot overflow stops the oscillators and switches all counters off
// - one interrupt; slot overflow sets its flag and the enabled-key request
// - sense counter overflow sets a sticky flag until software writes zero
// - function counter overflow sets a sticky flag until software clears it
// - sense oscillator cycles are counted during the fixed slot interval
// - each pad has its own oscillator; either may be the counted source
// - slot interval is (256 - preload) times 32 slot clock periods
// - function counter clock is sysclk divided by 1, 2, 4 or 8
// - two-bit frequency select gives 1, 3, 7 or 11 MHz, reset 11
module ctsc_top
	import ctsc_pkg::*;
(
	input  wire logic        aclk,            // system clock, 40 MHz
	input  wire logic        aresetn,         // synchronous reset
	input  wire logic        ce,              // clock enable
	input  wire logic        awvalid,         // write address valid
	output logic             awready,         // write address ready
	input  wire logic [31:0] awaddr,          // write address
	input  wire logic [2:0]  awprot,          // write protection, unused
	input  wire logic        wvalid,          // write data valid
	output logic             wready,          // write data ready
	input  wire logic [31:0] wdata,           // write data
	input  wire logic [3:0]  wstrb,           // write strobes
	output logic             bvalid,          // write response valid
	input  wire logic        bready,          // write response ready
	output logic [1:0]       bresp,           // write response
	input  wire logic        arvalid,         // read address valid
	output logic             arready,         // read address ready
	input  wire logic [31:0] araddr,          // read address
	input  wire logic [2:0]  arprot,          // read protection, unused
	output logic             rvalid,          // read data valid
	input  wire logic        rready,          // read data ready
	output logic [31:0]      rdata,           // read data
	output logic [1:0]       rresp,           // read response
	input  wire logic        pad_one_osc,     // pad one sense oscillator
	input  wire logic        pad_two_osc,     // pad two sense oscillator
	input  wire logic        ref_osc,         // reference oscillator
	output ctsc_osc_ctrl_t   osc_ctrl,        // oscillator and pad controls
	output logic             touch_irq_request // touch interrupt request
);

	logic [9:0]  ref_cap_code;
	logic [7:0]  control_0;
	logic [7:0]  control_1;
	logic        scan_start;
	logic        slot_overflow_flag;
	logic        sense_count_overflow_flag;
	logic        func_count_overflow_flag;
	logic        resv_bit;
	logic [1:0]  func_count_clock_select;
	logic [1:0]  osc_freq_select;
	logic [7:0]  slot_preload;
	logic [15:0] sense_count;
	logic [15:0] func_count;
	logic [4:0]  unit_count;
	logic [7:0]  slot_count;
	logic [2:0]  hop_index;
	logic [1:0]  slot_div;
	logic [2:0]  func_div;
	logic        start_prev;
	ctsc_state_t state;

	logic [2:0]  sync1;
	logic [2:0]  sync2;
	logic        key_prev;
	logic        ref_prev;

	logic        aw_held;
	logic        w_held;
	logic [5:0]  aw_addr;
	logic [31:0] w_data;
	logic        w_lane0;

	logic        running;
	logic        start_rise;
	logic        key_sel;
	logic        key_edge;
	logic        ref_rise;
	logic        slot_tick;
	logic        unit_wrap;
	logic        slot_ovf;
	logic        func_tick;
	logic        do_write;
	logic        wr_scan;
	logic [7:0]  wbyte;

	// oscillator inputs are asynchronous: two flops first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else if (ce) begin
			sync1 <= {ref_osc, pad_two_osc, pad_one_osc};
			sync2 <= sync1;
		end
	end

	assign running    = (state == CTSC_RUN);
	assign key_sel    = control_0[CTSC_C0_MUX_BIT] ? sync2[1] : sync2[0];
	// doubling counts both edges of the key oscillator
	assign key_edge   = control_0[CTSC_C0_DOUBLE_BIT] ? (key_sel != key_prev)
				: (key_sel && !key_prev);
	assign ref_rise   = sync2[2] && !ref_prev;
	assign slot_tick  = control_1[CTSC_C1_SLOTCLK_BIT] ?
				(slot_div == CTSC_SLOT_SYS_DIV_LAST) : ref_rise;
	assign unit_wrap  = running && slot_tick && (unit_count == CTSC_UNIT_LAST);
	assign slot_ovf   = unit_wrap && (slot_count == CTSC_SLOT_LAST);
	assign start_rise = scan_start && !start_prev;
	assign func_tick  = (func_div[2:0] & ((3'h1 << func_count_clock_select)
				- 3'h1)) == 3'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_prev   <= 1'b0;
			ref_prev   <= 1'b0;
			start_prev <= 1'b0;
			slot_div   <= 2'h0;
			func_div   <= 3'h0;
		end else if (ce) begin
			key_prev   <= key_sel;
			ref_prev   <= sync2[2];
			start_prev <= scan_start;
			slot_div   <= running ? slot_div + 2'h1 : 2'h0;
			func_div   <= running ? func_div + 3'h1 : 3'h0;
		end
	end

	// scan sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= CTSC_IDLE;
		end else if (ce) begin
			case (state)
			CTSC_IDLE: begin
				if (start_rise)
					state <= CTSC_RUN;
			end
			CTSC_RUN: begin
				if (!scan_start)
					state <= CTSC_IDLE;
				else if (slot_ovf)
					state <= CTSC_DONE;
			end
			CTSC_DONE: begin
				if (!scan_start)
					state <= CTSC_IDLE;
			end
			default: state <= CTSC_IDLE;
			endcase
		end
	end

	// measurement counters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sense_count <= 16'h0000;
			func_count  <= 16'h0000;
			unit_count  <= 5'h00;
		end else if (ce) begin
			if (!scan_start || start_rise) begin
				sense_count <= 16'h0000;
				func_count  <= 16'h0000;
				unit_count  <= 5'h00;
			end else if (running) begin
				if (key_edge && control_1[CTSC_C1_KEYOSC_BIT])
					sense_count <= sense_count + 16'h0001;
				if (func_tick)
					func_count <= func_count + 16'h0001;
				if (slot_tick)
					unit_count <= unit_count + 5'h01;
			end
		end
	end

	// slot counter keeps its value while idle, loads on start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slot_count <= 8'h00;
		end else if (ce) begin
			if (start_rise)
				slot_count <= slot_preload;
			else if (unit_wrap && !slot_ovf)
				slot_count <= slot_count + 8'h01;
		end
	end

	// hardware hopping advances once per unit period
	always_ff @(posedge aclk) begin
		if (!aresetn)
			hop_index <= 3'h0;
		else if (ce && unit_wrap && control_0[CTSC_C0_HOPSEL_BIT])
			hop_index <= hop_index + 3'h1;
	end

	// AXI4-Lite write channel
	assign do_write = aw_held && w_held && !bvalid;
	assign wbyte    = w_data[7:0];
	assign wr_scan  = do_write && w_lane0 && (aw_addr == CTSC_ADDR_SCAN_CTRL);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 6'h00;
			w_data  <= 32'h0000_0000;
			w_lane0 <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= CTSC_RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				awready <= 1'b0;
				aw_addr <= awaddr[5:0];
			end
			if (wvalid && wready) begin
				w_held  <= 1'b1;
				wready  <= 1'b0;
				w_data  <= wdata;
				w_lane0 <= wstrb[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= (aw_addr[1:0] == 2'h0 && aw_addr <= CTSC_ADDR_STATUS)
					? CTSC_RESP_OKAY : CTSC_RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// software-written configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_cap_code            <= {2'h0, CTSC_RST_BYTE};
			control_0               <= CTSC_RST_BYTE;
			control_1               <= CTSC_RST_BYTE;
			scan_start              <= 1'b0;
			resv_bit                <= 1'b0;
			func_count_clock_select <= 2'h0;
			osc_freq_select         <= CTSC_RST_FREQ_SEL;
			slot_preload            <= CTSC_RST_BYTE;
		end else if (ce && do_write && w_lane0) begin
			case (aw_addr)
			CTSC_ADDR_REF_CAP_LOW:  ref_cap_code[7:0] <= wbyte;
			CTSC_ADDR_REF_CAP_HIGH: ref_cap_code[9:8] <= wbyte[1:0];
			CTSC_ADDR_CONTROL_0:    control_0 <= wbyte & 8'h6f;
			CTSC_ADDR_CONTROL_1:    control_1 <= wbyte & 8'hb3;
			CTSC_ADDR_SCAN_CTRL: begin
				scan_start              <= wbyte[CTSC_SC_START_BIT];
				resv_bit                <= wbyte[CTSC_SC_RESV_BIT];
				func_count_clock_select <= wbyte[CTSC_SC_FCLK_LSB +: 2];
			end
			CTSC_ADDR_FREQ_SEL:     osc_freq_select <= wbyte[1:0];
			CTSC_ADDR_SLOT_PRELOAD: slot_preload <= wbyte;
			default: ;
			endcase
		end
	end

	// sticky flags: hardware set wins over software clear; writing 1 keeps
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slot_overflow_flag        <= 1'b0;
			sense_count_overflow_flag <= 1'b0;
			func_count_overflow_flag  <= 1'b0;
		end else if (ce) begin
			if (slot_ovf)
				slot_overflow_flag <= 1'b1;
			else if (wr_scan && !wbyte[CTSC_SC_SLOT_OVF_BIT])
				slot_overflow_flag <= 1'b0;
			if (running && key_edge && control_1[CTSC_C1_KEYOSC_BIT]
			    && sense_count == 16'hffff && scan_start)
				sense_count_overflow_flag <= 1'b1;
			else if (wr_scan && !wbyte[CTSC_SC_SENSE_OVF_BIT])
				sense_count_overflow_flag <= 1'b0;
			if (running && func_tick && func_count == 16'hffff && scan_start)
				func_count_overflow_flag <= 1'b1;
			else if (wr_scan && !wbyte[CTSC_SC_FUNC_OVF_BIT])
				func_count_overflow_flag <= 1'b0;
		end
	end

	// touch request: raised on slot overflow when a pad is a touch input
	always_ff @(posedge aclk) begin
		if (!aresetn)
			touch_irq_request <= 1'b0;
		else if (ce)
			touch_irq_request <= (slot_ovf && (control_1[CTSC_C1_PAD1_BIT]
				|| control_1[CTSC_C1_PAD2_BIT])) || (touch_irq_request
				&& slot_overflow_flag);
	end

	// oscillator and pad controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_ctrl <= '0;
		end else if (ce) begin
			osc_ctrl.ref_osc_run <= control_1[CTSC_C1_REFOSC_BIT]
				&& running && !slot_ovf;
			osc_ctrl.key_osc_run <= control_1[CTSC_C1_KEYOSC_BIT]
				&& running && !slot_ovf;
			osc_ctrl.osc_sync           <= start_rise;
			osc_ctrl.key_mux_select     <= control_0[CTSC_C0_MUX_BIT];
			osc_ctrl.freq_double_enable <= control_0[CTSC_C0_DOUBLE_BIT];
			osc_ctrl.hop_code <= control_0[CTSC_C0_HOPSEL_BIT] ? hop_index
				: control_0[CTSC_C0_HOP_LSB +: 3];
			osc_ctrl.osc_freq_select    <= osc_freq_select;
			osc_ctrl.ref_cap_code       <= ref_cap_code;
			osc_ctrl.pad_one_function   <= control_1[CTSC_C1_PAD1_BIT];
			osc_ctrl.pad_two_function   <= control_1[CTSC_C1_PAD2_BIT];
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= CTSC_RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rresp   <= CTSC_RESP_OKAY;
				case (araddr[5:0])
				CTSC_ADDR_REF_CAP_LOW:  rdata <= {24'h0, ref_cap_code[7:0]};
				CTSC_ADDR_REF_CAP_HIGH: rdata <= {30'h0, ref_cap_code[9:8]};
				CTSC_ADDR_CONTROL_0:    rdata <= {24'h0, control_0};
				CTSC_ADDR_CONTROL_1:    rdata <= {24'h0, control_1};
				CTSC_ADDR_SCAN_CTRL:    rdata <= {25'h0, slot_overflow_flag,
					scan_start, sense_count_overflow_flag,
					func_count_overflow_flag, resv_bit,
					func_count_clock_select};
				CTSC_ADDR_FREQ_SEL:     rdata <= {30'h0, osc_freq_select};
				CTSC_ADDR_SLOT_PRELOAD: rdata <= {24'h0, slot_preload};
				CTSC_ADDR_FUNC_COUNT:   rdata <= {16'h0, func_count};
				CTSC_ADDR_SENSE_COUNT:  rdata <= {16'h0, sense_count};
				CTSC_ADDR_STATUS:       rdata <= {16'h0, slot_count, 1'b0,
					hop_index, 1'b0, state};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= CTSC_RESP_SLVERR;
				end
				endcase
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule

// File: design/ctsc_pkg.sv
package ctsc_pkg;

	// register byte addresses on the AXI4-Lite slave
	localparam logic [5:0] CTSC_ADDR_REF_CAP_LOW  = 6'h00;
	localparam logic [5:0] CTSC_ADDR_REF_CAP_HIGH = 6'h04;
	localparam logic [5:0] CTSC_ADDR_CONTROL_0    = 6'h08;
	localparam logic [5:0] CTSC_ADDR_CONTROL_1    = 6'h0c;
	localparam logic [5:0] CTSC_ADDR_SCAN_CTRL    = 6'h10;
	localparam logic [5:0] CTSC_ADDR_FREQ_SEL     = 6'h14;
	localparam logic [5:0] CTSC_ADDR_SLOT_PRELOAD = 6'h18;
	localparam logic [5:0] CTSC_ADDR_FUNC_COUNT   = 6'h1c;
	localparam logic [5:0] CTSC_ADDR_SENSE_COUNT  = 6'h20;
	localparam logic [5:0] CTSC_ADDR_STATUS       = 6'h24;

	// control register 0 fields
	localparam int CTSC_C0_MUX_BIT    = 6;
	localparam int CTSC_C0_DOUBLE_BIT = 5;
	localparam int CTSC_C0_HOPSEL_BIT = 3;
	localparam int CTSC_C0_HOP_LSB    = 0;
	// control register 1 fields
	localparam int CTSC_C1_SLOTCLK_BIT = 7;
	localparam int CTSC_C1_REFOSC_BIT  = 5;
	localparam int CTSC_C1_KEYOSC_BIT  = 4;
	localparam int CTSC_C1_PAD2_BIT    = 1;
	localparam int CTSC_C1_PAD1_BIT    = 0;
	// scan control register fields
	localparam int CTSC_SC_SLOT_OVF_BIT  = 6;
	localparam int CTSC_SC_START_BIT     = 5;
	localparam int CTSC_SC_SENSE_OVF_BIT = 4;
	localparam int CTSC_SC_FUNC_OVF_BIT  = 3;
	localparam int CTSC_SC_RESV_BIT      = 2;
	localparam int CTSC_SC_FCLK_LSB      = 0;

	// reset values
	localparam logic [7:0] CTSC_RST_BYTE     = 8'h00;
	localparam logic [1:0] CTSC_RST_FREQ_SEL = 2'h3;

	// reference capacitance: code * 50 pF / 1024
	localparam int CTSC_REF_CAP_FULL_PF = 50;
	localparam int CTSC_REF_CAP_STEPS   = 1024;

	// timing: slot clock from system clock / 4, unit period of 32 slots
	localparam logic [1:0] CTSC_SLOT_SYS_DIV_LAST = 2'h3;
	localparam logic [4:0] CTSC_UNIT_LAST         = 5'h1f;
	localparam logic [7:0] CTSC_SLOT_LAST         = 8'hff;

	localparam logic [1:0] CTSC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CTSC_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CTSC_IDLE = 3'b001,
		CTSC_RUN  = 3'b010,
		CTSC_DONE = 3'b100
	} ctsc_state_t;

	// controls toward the analog oscillators and pads
	typedef struct packed {
		logic       ref_osc_run;
		logic       key_osc_run;
		logic       osc_sync;
		logic       key_mux_select;
		logic       freq_double_enable;
		logic [2:0] hop_code;
		logic [1:0] osc_freq_select;
		logic [9:0] ref_cap_code;
		logic       pad_one_function;
		logic       pad_two_function;
	} ctsc_osc_ctrl_t;

endpackage

// File: verification/ctsc_pad_model.sv
`timescale 1ns/10ps
module ctsc_pad_model
	import ctsc_pkg::*;
#(
	parameter int HALF_ONE = 60,
	parameter int HALF_TWO = 140,
	parameter int HALF_REF = 45
)(
	input  wire ctsc_osc_ctrl_t osc_ctrl,    // controls from the block
	output logic                pad_one_osc, // pad one sense oscillator
	output logic                pad_two_osc, // pad two sense oscillator
	output logic                ref_osc      // reference oscillator
);
	initial begin
		pad_one_osc = 1'b0;
		pad_two_osc = 1'b0;
		ref_osc = 1'b0;
	end

	// each pad runs only while its key oscillator is on and it is a key
	always #(HALF_ONE) if (osc_ctrl.key_osc_run && osc_ctrl.pad_one_function)
		pad_one_osc = ~pad_one_osc;
	always #(HALF_TWO) if (osc_ctrl.key_osc_run && osc_ctrl.pad_two_function)
		pad_two_osc = ~pad_two_osc;
	always #(HALF_REF) if (osc_ctrl.ref_osc_run)
		ref_osc = ~ref_osc;
endmodule

// File: verification/ctsc_checker.sv
`timescale 1ns/10ps
module ctsc_checker
	import ctsc_pkg::*;
(
	input wire logic           aclk,             // clock
	input wire logic           aresetn,          // reset, active low
	input wire logic           bvalid,           // write response valid
	input wire ctsc_osc_ctrl_t osc_ctrl,         // oscillator controls
	input wire logic           touch_irq_request // touch request
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_cap_code_held: assert property (
		$changed(osc_ctrl.ref_cap_code) |-> $past(bvalid))
		else $error("cap code changed without a write");
	a_mux_sel_held: assert property (
		$changed(osc_ctrl.key_mux_select) |-> $past(bvalid))
		else $error("key select changed without a write");
	a_double_held: assert property (
		$changed(osc_ctrl.freq_double_enable) |-> $past(bvalid))
		else $error("doubling changed without a write");
	a_pad_func_held: assert property (
		$changed({osc_ctrl.pad_one_function, osc_ctrl.pad_two_function})
		|-> $past(bvalid))
		else $error("pad function changed without a write");
	a_sync_pulse: assert property (
		osc_ctrl.osc_sync |=> !osc_ctrl.osc_sync)
		else $error("sync pulse longer than one cycle");
	a_stop_on_ovf: assert property (
		$rose(touch_irq_request) |-> ##[0:3]
		(!osc_ctrl.key_osc_run && !osc_ctrl.ref_osc_run))
		else $error("oscillators still run after overflow");
	a_irq_needs_pad: assert property (
		$rose(touch_irq_request) |->
		(osc_ctrl.pad_one_function || osc_ctrl.pad_two_function))
		else $error("request raised with no key enabled");
	a_irq_sticky: assert property (
		$fell(touch_irq_request) |-> $past(bvalid))
		else $error("request dropped without a write");
endmodule

bind ctsc_top ctsc_checker chk_i (
	.aclk(aclk),
	.aresetn(aresetn),
	.bvalid(bvalid),
	.osc_ctrl(osc_ctrl),
	.touch_irq_request(touch_irq_request)
);

// File: verification/capacitive_touch_scan_control_test.sv
`timescale 1ns/10ps
module capacitive_touch_scan_control_test;
	import ctsc_pkg::*;
	logic           aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [31:0]    awaddr, wdata, araddr, rdata, v;
	logic           awready, wready, bvalid, arready, rvalid, irq;
	logic           p1, p2, ro;
	logic [1:0]     bresp, rresp, r;
	ctsc_osc_ctrl_t oc;
	int             n_mismatch = 0;
	int             n_tests = 0;
	int             cyc = 0;
	logic [7:0]     msk [4] = '{8'hff, 8'h03, 8'h6f, 8'hb3};

	initial aclk = 1'b0;
	always #12.5 aclk = ~aclk;

	ctsc_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .pad_one_osc(p1), .pad_two_osc(p2), .ref_osc(ro),
		.osc_ctrl(oc), .touch_irq_request(irq));
	ctsc_pad_model pads (.osc_ctrl(oc), .pad_one_osc(p1),
		.pad_two_osc(p2), .ref_osc(ro));

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= {26'h0, a};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a);
		@(posedge aclk);
		araddr <= {26'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// one scan of (256 - 0xfe) * 32 slot ticks; f is the function clock
	// select, e the function count that interval should give
	task automatic scan(input logic [7:0] c0, input logic hi,
		input logic [1:0] f, input logic [31:0] e);
		int i;
		wr(CTSC_ADDR_CONTROL_0, c0);
		wr(CTSC_ADDR_SCAN_CTRL, {6'h08, f});
		i = 0;
		while (irq !== 1'b1 && i < 2000) begin
			@(posedge aclk);
			i++;
		end
		chk({31'h0, irq}, 32'h1);
		rd(CTSC_ADDR_STATUS);
		chk(v & 32'h7, 32'h4);
		rd(CTSC_ADDR_SCAN_CTRL);
		chk(v, {30'h0, f} | 32'h60);
		rd(CTSC_ADDR_FUNC_COUNT);
		chk({31'h0, v + 32'h5 >= e && v <= e + 32'h5}, 32'h1);
		rd(CTSC_ADDR_SENSE_COUNT);
		chk({31'h0, v > 32'h26}, {31'h0, hi});
		wr(CTSC_ADDR_SCAN_CTRL, {6'h08, f});
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		wr(CTSC_ADDR_SCAN_CTRL, 8'h00);
		rd(CTSC_ADDR_STATUS);
		chk(v & 32'hff07, 32'hff01);
		rd(CTSC_ADDR_SENSE_COUNT);
		chk(v, 32'h0);
		rd(CTSC_ADDR_FUNC_COUNT);
		chk(v, 32'h0);
	endtask

	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 32'h0;
		wdata = 32'h0;
		araddr = 32'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			rd(6'(i * 4));
			chk(v, i == 5 ? 32'h3 : i == 9 ? 32'h1 : 32'h0);
		end
		for (int i = 0; i < 4; i++) begin
			wr(6'(i * 4), 8'hff);
			rd(6'(i * 4));
			chk(v, {24'h0, msk[i]});
		end
		chk({22'h0, oc.ref_cap_code}, 32'h3ff);
		chk({30'h0, oc.osc_freq_select}, 32'h3);
		chk({29'h0, oc.key_mux_select, oc.pad_one_function,
			oc.pad_two_function}, 32'h7);
		wr(CTSC_ADDR_CONTROL_0, 8'h05);
		repeat (2) @(posedge aclk);
		chk({29'h0, oc.hop_code}, 32'h5);
		wr(CTSC_ADDR_SCAN_CTRL, 8'h58);
		rd(CTSC_ADDR_SCAN_CTRL);
		chk(v, 32'h0);
		wr(6'h28, 8'h01);
		chk({30'h0, r}, {30'h0, CTSC_RESP_SLVERR});
		rd(6'h28);
		chk({30'h0, r}, {30'h0, CTSC_RESP_SLVERR});
		chk(v, 32'h0);
		wr(CTSC_ADDR_CONTROL_1, 8'hb3);
		wr(CTSC_ADDR_SLOT_PRELOAD, 8'hfe);
		scan(8'h00, 1'b1, 2'h0, 32'h100);
		scan(8'h40, 1'b0, 2'h1, 32'h80);
		scan(8'h60, 1'b1, 2'h3, 32'h20);
		// hardware hopping: two unit periods per scan advance the index twice
		scan(8'h08, 1'b1, 2'h2, 32'h40);
		rd(CTSC_ADDR_STATUS);
		chk(v & 32'h70, 32'h20);
		chk({29'h0, oc.hop_code}, 32'h2);
		// slot clock from the reference oscillator: 64 periods of 90 ns
		wr(CTSC_ADDR_CONTROL_1, 8'h33);
		scan(8'h00, 1'b1, 2'h0, 32'he7);
		tally_and_finish();
	end
endmodule
